// *** logic/swg_gate_ctrl.sv ***
// gate_controller: potential mode, emergency unblock, overload, power supervision
//
// Operation
// R1 - while a direction level is held, open that way and stay open
// R2 - held panel halt button locks the gate despite connector requests
// R3 - connector direction level dropping makes the gate lock
// R4 - connector halt input has no effect in potential mode
// R5 - held panel direction button opens that way until released
// R6 - opened unblock contacts free the panel and cut drive power always
// R7 - unblock contacts closing repeat power-up then always-locked
// R8 - forced against drive over 10 seconds enters overload
// R9 - overload blinks all three indicators, three beeps every 20 seconds
// R10 - overload ends only when panel is back home; code also leaves it on opened unblock contacts or battery cutoff
// R11 - mains loss switches to standby battery if battery switch on
// R12 - on battery mains indicator off, battery indicator on
// R13 - mains loss asserts mains-failure status on connector
// R14 - about 5 seconds after mains loss flash panel at 1 second
// R15 - battery-low flag asserts battery-failure status on connector
// R16 - battery-low gives six short beeps every 30 seconds
// R17 - battery cutoff enters malfunction and switches off
// R18 - mains back with mains switch on resumes normal operation
// R19 - power-up lights all, two tones, after 3 s halt only, home, lock
// R20 - access control holds the level of the chosen direction
// R21 - all contacts synchronised and debounced before use
// R22 - configuration selects pulse or potential interpretation only
//
// Local design decisions: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
module swg_gate_ctrl #(
  parameter logic [swg_pkg::CW-1:0] P_DEB_CYC       = swg_pkg::C_DEB,
  parameter logic [swg_pkg::CW-1:0] P_BOOT_CYC      = swg_pkg::C_BOOT,
  parameter logic [swg_pkg::CW-1:0] P_OVL_CYC       = swg_pkg::C_OVL,
  parameter logic [swg_pkg::CW-1:0] P_OVL_PER_CYC   = swg_pkg::C_OVL_PER,
  parameter logic [swg_pkg::CW-1:0] P_FLASH_DLY_CYC = swg_pkg::C_FLASH_DLY,
  parameter logic [swg_pkg::CW-1:0] P_FLASH_CYC     = swg_pkg::C_FLASH,
  parameter logic [swg_pkg::CW-1:0] P_BAT_PER_CYC   = swg_pkg::C_BAT_PER,
  parameter logic [swg_pkg::CW-1:0] P_BEEP_CYC      = swg_pkg::C_BEEP
) (
  input  wire logic                  ref_clk,  // 200 MHz system clock
  input  wire logic                  rst,      // synchronous reset, high
  input  wire logic                  wb_cyc_i, // wishbone cycle
  input  wire logic                  wb_stb_i, // wishbone strobe
  input  wire logic                  wb_we_i,  // wishbone write
  input  wire logic [3:0]            wb_adr_i, // wishbone byte address
  input  wire logic [3:0]            wb_sel_i, // wishbone byte enables
  input  wire logic [31:0]           wb_dat_i, // wishbone write data
  output logic      [31:0]           wb_dat_o, // wishbone read data
  output logic                       wb_ack_o, // wishbone acknowledge
  input  wire swg_pkg::swg_contacts_t contacts, // raw contact levels
  output swg_pkg::swg_drive_t        drive     // drive, lock and indicators
);
  import swg_pkg::*;

  swg_contacts_t    s1_q, s2_q, deb_q;
  logic [CW-1:0]    deb_cnt_q;
  swg_state_t       st_q, st_d;
  logic [CW-1:0]    st_cnt_q, ovl_cnt_q, mains_cnt_q, flash_cnt_q;
  logic [CW-1:0]    per_cnt_q, slot_cnt_q;
  logic             flash_q, beep_q, pulse_q, ack_q;
  logic [3:0]       left_q;
  logic [31:0]      rdat_q;
  swg_drive_t       drive_q, drive_d;

  // debounce: the whole vector is taken once it has differed from deb_q for P_DEB_CYC cycles running; a return to deb_q restarts
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s1_q      <= CONTACTS_RST;
      s2_q      <= CONTACTS_RST;
      deb_q     <= CONTACTS_RST;
      deb_cnt_q <= '0;
    end else begin
      s1_q <= contacts;                                      // [R21]
      s2_q <= s1_q;
      if (s2_q == deb_q) begin
        deb_cnt_q <= '0;
      end else if (swg_hit(deb_cnt_q, P_DEB_CYC)) begin
        deb_q     <= s2_q;                                   // [R21]
        deb_cnt_q <= '0;
      end else begin
        deb_cnt_q <= deb_cnt_q + CW'(1);
      end
    end
  end

  // request decode
  wire potential = !pulse_q;                                 // [R22]
  wire halt      = deb_q.pnl_halt;                           // [R2] [R4]
  wire req_l     = deb_q.pnl_left | deb_q.acs_left;          // [R1] [R5]
  wire req_r     = deb_q.pnl_right | deb_q.acs_right;        // [R1] [R5]
  wire open_l    = potential & !halt & req_l & !req_r;       // [R1] [R2]
  wire open_r    = potential & !halt & req_r & !req_l;       // [R1] [R2]
  wire on_batt   = !(deb_q.mains_ok & deb_q.pwr_sw_on);      // [R11] [R18]
  wire dead      = on_batt & (deb_q.bat_cut | !deb_q.bat_sw_on); // [R17] [R11]
  wire driving   = st_q inside {ST_OPEN_L, ST_OPEN_R, ST_HOMING};
  wire forcing   = driving & deb_q.force_back;
  wire ovl_hit   = forcing & swg_hit(ovl_cnt_q, P_OVL_CYC);  // [R8]
  wire boot_done = (st_q == ST_BOOT) & swg_hit(st_cnt_q, P_BOOT_CYC);
  wire flash_en  = on_batt & swg_hit(mains_cnt_q, P_FLASH_DLY_CYC); // [R14]
  wire alarm_ovl = st_q == ST_OVERLOAD;
  wire alarm_bat = deb_q.bat_low & !alarm_ovl;
  wire alarm     = alarm_ovl | alarm_bat;
  wire [CW-1:0] per_lim = alarm_ovl ? P_OVL_PER_CYC : P_BAT_PER_CYC;
  wire [3:0]    burst_n = alarm_ovl ? OVL_BEEPS : BAT_BEEPS;
  wire burst_start = alarm & (per_cnt_q == '0);              // [R9] [R16]
  wire slot_wrap   = swg_hit(slot_cnt_q, P_BEEP_CYC);

  always_comb begin
    st_d = st_q;
    if (st_q == ST_OFF) begin
      if (!on_batt) st_d = ST_BOOT;                           // [R18]
    end else if (dead) begin
      st_d = ST_OFF;                                          // [R17]
    end else if (!deb_q.unblock_ok) begin
      st_d = ST_UNBLOCK;                                      // [R6]
    end else if (ovl_hit) begin
      st_d = ST_OVERLOAD;                                     // [R8]
    end else begin
      unique case (st_q)
        ST_BOOT: begin
          if (boot_done) st_d = deb_q.at_home ? ST_LOCKED : ST_HOMING; // [R19]
        end
        ST_HOMING, ST_LOCKED: begin
          if (open_l) st_d = ST_OPEN_L;                       // [R1] [R5]
          else if (open_r) st_d = ST_OPEN_R;                  // [R1] [R5]
          else if (deb_q.at_home) st_d = ST_LOCKED;
          else st_d = ST_HOMING;
        end
        ST_OPEN_L: begin
          if (!open_l) st_d = ST_HOMING;                      // [R2] [R3]
        end
        ST_OPEN_R: begin
          if (!open_r) st_d = ST_HOMING;                      // [R2] [R3]
        end
        ST_UNBLOCK:  st_d = ST_BOOT;                          // [R7]
        ST_OVERLOAD: begin
          if (deb_q.at_home) st_d = ST_LOCKED;                // [R10]
        end
        ST_OFF:      st_d = ST_OFF;
      endcase
    end
  end

  // outputs
  always_comb begin
    drive_d              = '0;
    drive_d.lock_on      = st_q inside {ST_BOOT, ST_LOCKED, ST_HOMING};
    drive_d.drive_power  = !(st_q inside {ST_UNBLOCK, ST_OVERLOAD, ST_OFF}); // [R6]
    drive_d.motor_left   = st_q == ST_OPEN_L;
    drive_d.motor_right  = st_q == ST_OPEN_R;
    drive_d.motor_home   = st_q == ST_HOMING;
    drive_d.ind_left     = st_q == ST_OPEN_L;
    drive_d.ind_right    = st_q == ST_OPEN_R;
    drive_d.ind_halt     = st_q inside {ST_LOCKED, ST_HOMING}; // [R19]
    if (flash_en & !flash_q) begin
      drive_d.ind_left  = 1'b0;                              // [R14]
      drive_d.ind_right = 1'b0;
      drive_d.ind_halt  = 1'b0;
    end
    if (st_q == ST_BOOT) begin
      drive_d.ind_left  = 1'b1;                              // [R19]
      drive_d.ind_right = 1'b1;
      drive_d.ind_halt  = 1'b1;
    end
    if (alarm_ovl) begin
      drive_d.ind_left  = flash_q;                           // [R9]
      drive_d.ind_right = flash_q;
      drive_d.ind_halt  = flash_q;
    end
    drive_d.ind_mains    = !on_batt;                         // [R12]
    drive_d.ind_battery  = on_batt & deb_q.bat_sw_on & (st_q != ST_OFF); // [R12]
    drive_d.acs_pwr_fail = !deb_q.mains_ok;                  // [R13]
    drive_d.acs_bat_fail = deb_q.bat_low;                    // [R15]
    drive_d.beeper       = (st_q == ST_BOOT) | beep_q;       // [R19] [R9] [R16]
    drive_d.tone_hi      = (st_q == ST_BOOT) & flash_q;      // [R19]
    drive_d.power_off    = st_q == ST_OFF;                   // [R17]
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_q    <= ST_BOOT;
      drive_q <= '0;
    end else begin
      st_q    <= st_d;
      drive_q <= drive_d;
    end
  end

  // timers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_cnt_q    <= '0;
      ovl_cnt_q   <= '0;
      mains_cnt_q <= '0;
      flash_cnt_q <= '0;
      flash_q     <= 1'b0;
    end else begin
      st_cnt_q <= (st_q != st_d) ? '0 : st_cnt_q + CW'(1);
      if (!forcing) ovl_cnt_q <= '0;                          // [R8]
      else if (!ovl_hit) ovl_cnt_q <= ovl_cnt_q + CW'(1);
      if (!on_batt) mains_cnt_q <= '0;
      else if (!flash_en) mains_cnt_q <= mains_cnt_q + CW'(1);
      if (swg_hit(flash_cnt_q, P_FLASH_CYC)) begin
        flash_cnt_q <= '0;
        flash_q     <= !flash_q;                              // [R14]
      end else begin
        flash_cnt_q <= flash_cnt_q + CW'(1);
      end
    end
  end

  // beep bursts; overload alarm takes priority over battery alarm
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      per_cnt_q  <= '0;
      slot_cnt_q <= '0;
      left_q     <= '0;
      beep_q     <= 1'b0;
    end else begin
      slot_cnt_q <= slot_wrap ? '0 : slot_cnt_q + CW'(1);
      if (!alarm || swg_hit(per_cnt_q, per_lim)) per_cnt_q <= '0;
      else per_cnt_q <= per_cnt_q + CW'(1);
      if (!alarm) begin
        left_q <= '0;
        beep_q <= 1'b0;
      end else begin
        if (burst_start) left_q <= burst_n;                   // [R9] [R16]
        else if (slot_wrap && beep_q) left_q <= left_q - 4'h1;
        if (slot_wrap) beep_q <= !beep_q && (left_q != 4'h0);
      end
    end
  end

  // wishbone slave, one wait state, unmapped reads give zero
  wire wb_req = wb_cyc_i & wb_stb_i & !ack_q;
  wire [31:0] rd_mux = (wb_adr_i == ADR_CTRL) ? {31'h0, pulse_q} :
                       (wb_adr_i == ADR_STAT) ?
                       {23'h0, pulse_q, deb_q.at_home, deb_q.bat_low, flash_en,
                        on_batt, 4'(st_q)} : 32'h0;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ack_q   <= 1'b0;
      rdat_q  <= '0;
      pulse_q <= RST_PULSE;
    end else begin
      ack_q  <= wb_req;
      rdat_q <= wb_req ? rd_mux : '0;
      if (wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == ADR_CTRL)
        pulse_q <= wb_dat_i[CTRL_PULSE];                      // [R22]
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign drive    = drive_q;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  wire calm = deb_q.unblock_ok & !dead & !ovl_hit & st_q != ST_OFF;
  sequence s_freed;
    st_q == ST_UNBLOCK ##1 !drive.drive_power && !drive.lock_on;
  endsequence
  sequence s_reboot;
    st_q == ST_BOOT ##1 drive.ind_left && drive.ind_halt && drive.beeper;
  endsequence

  AST_OPEN_HOLD: assert property (st_q == ST_OPEN_L && open_l && calm |=> st_q == ST_OPEN_L)
    else $error("gate closed while request held"); // [R1] [R5]
  AST_HALT_LOCKS: assert property (halt && calm && st_q == ST_OPEN_R |=> st_q == ST_HOMING)
    else $error("halt did not lock"); // [R2]
  AST_DROP_LOCKS: assert property (st_q == ST_OPEN_L && !req_l && calm |=> st_q == ST_HOMING)
    else $error("request drop did not lock"); // [R3]
  AST_ACS_HALT_IGNORED: assert property (st_q == ST_LOCKED && calm && potential
      && deb_q.acs_halt && deb_q.acs_left && !req_r && !halt |=> st_q == ST_OPEN_L)
    else $error("connector halt acted in potential mode"); // [R4]
  AST_UNBLOCK: assert property (!deb_q.unblock_ok && !dead && st_q != ST_OFF |=> s_freed)
    else $error("unblock did not free panel"); // [R6]
  AST_REBOOT: assert property (st_q == ST_UNBLOCK && deb_q.unblock_ok && !dead |=> s_reboot)
    else $error("no power-up after unblock release"); // [R7]
  AST_OVL_ENTER: assert property (ovl_hit && deb_q.unblock_ok && !dead
      |=> st_q == ST_OVERLOAD ##1 !drive.drive_power)
    else $error("overload not entered"); // [R8]
  AST_OVL_BURST: assert property (alarm_ovl && burst_start |=> left_q == 4'h3)
    else $error("overload burst count wrong"); // [R9]
  AST_OVL_EXIT: assert property (st_q == ST_OVERLOAD && !deb_q.at_home && calm
      |=> st_q == ST_OVERLOAD)
    else $error("overload left away from home"); // [R10]
  AST_PWR_FAIL: assert property (!deb_q.mains_ok ##1 !deb_q.mains_ok
      |-> drive.acs_pwr_fail && !drive.ind_mains)
    else $error("mains failure not reported"); // [R12] [R13]
  AST_BAT_BURST: assert property (alarm_bat && burst_start |=> left_q == 4'h6)
    else $error("battery burst count wrong"); // [R16]
  AST_CUTOFF: assert property (dead && st_q != ST_OFF |=> st_q == ST_OFF ##1 drive.power_off)
    else $error("cutoff did not switch off"); // [R17]

  // single-step checks on the state register, the registered drive image, beep_q and ack_q
  AST_PULSE_LOCKED: assert property (pulse_q && st_q == ST_LOCKED && deb_q.at_home && calm
      |=> st_q == ST_LOCKED)
    else $error("pulse mode opened on a level"); // [R22]

  AST_OPEN_R_HOLD: assert property (st_q == ST_OPEN_R && open_r && calm
      |=> st_q == ST_OPEN_R)
    else $error("right opening dropped while held"); // [R1] [R5]

  AST_DROP_R_LOCKS: assert property (st_q == ST_OPEN_R && !req_r && calm
      |=> st_q == ST_HOMING)
    else $error("right request drop did not lock"); // [R3]

  AST_HALT_L_LOCKS: assert property (halt && calm && st_q == ST_OPEN_L
      |=> st_q == ST_HOMING)
    else $error("halt did not lock left opening"); // [R2]

  AST_OPEN_DRIVE: assert property (st_q == ST_OPEN_L
      |=> drive.motor_left && !drive.lock_on)
    else $error("left opening not driven"); // [R1]

  AST_HOME_MOTOR: assert property (st_q == ST_HOMING
      |=> drive.motor_home && drive.lock_on)
    else $error("homing not driven"); // [R3]

  AST_MAINS_IND: assert property (on_batt
      |=> !drive.ind_mains)
    else $error("mains indicator lit on battery"); // [R12]

  AST_BAT_IND: assert property (on_batt && deb_q.bat_sw_on && st_q != ST_OFF
      |=> drive.ind_battery)
    else $error("battery indicator dark on battery"); // [R12]

  AST_BAT_FAIL: assert property (deb_q.bat_low
      |=> drive.acs_bat_fail)
    else $error("battery failure not reported"); // [R15]

  AST_MAINS_BACK: assert property (st_q == ST_OFF && !on_batt
      |=> st_q == ST_BOOT)
    else $error("no restart on mains return"); // [R18]

  AST_BOOT_LOCK: assert property (boot_done && calm && deb_q.at_home
      |=> st_q == ST_LOCKED)
    else $error("boot did not end locked"); // [R19]

  AST_OVL_FREE: assert property (st_q == ST_OVERLOAD
      |=> !drive.drive_power && !drive.lock_on)
    else $error("drive powered in overload"); // [R8]

  AST_OVL_BLINK: assert property (alarm_ovl
      |=> drive.ind_halt == $past(flash_q))
    else $error("overload indicators not blinking"); // [R9]

  AST_FLASH_GATE: assert property (flash_en && !flash_q && st_q == ST_LOCKED
      |=> !drive.ind_halt)
    else $error("panel not flashing on battery"); // [R14]

  AST_OFF_POWER: assert property (st_q == ST_OFF
      |=> drive.power_off)
    else $error("switch-off not requested"); // [R17]

  AST_NO_ALARM_QUIET: assert property (!alarm
      |=> !beep_q)
    else $error("beep without alarm"); // [R9] [R16]

  AST_ACK_ONE: assert property (ack_q
      |=> !ack_q)
    else $error("acknowledge longer than one cycle");
endmodule // swg_gate_ctrl

// *** logic/swg_pkg.sv ***
// shared constants, types and helpers for the swing gate mode controller
package swg_pkg;
  localparam int unsigned CW      = 36;     // width of all long timers
  localparam int unsigned CLK_KHZ = 200000; // ref_clk rate, 200 MHz
  // times in milliseconds
  localparam int unsigned T_DEB_MS      = 10;
  localparam int unsigned T_BOOT_MS     = 3000;
  localparam int unsigned T_OVL_MS      = 10000;
  localparam int unsigned T_OVL_PER_MS  = 20000;
  localparam int unsigned T_FLASH_DLY_MS = 5000;
  localparam int unsigned T_FLASH_MS    = 1000;
  localparam int unsigned T_BAT_PER_MS  = 30000;
  localparam int unsigned T_BEEP_MS     = 100;
  // cycle counts derived from the times
  localparam logic [CW-1:0] C_DEB       = CW'(64'(T_DEB_MS) * CLK_KHZ);
  localparam logic [CW-1:0] C_BOOT      = CW'(64'(T_BOOT_MS) * CLK_KHZ);
  localparam logic [CW-1:0] C_OVL       = CW'(64'(T_OVL_MS) * CLK_KHZ);
  localparam logic [CW-1:0] C_OVL_PER   = CW'(64'(T_OVL_PER_MS) * CLK_KHZ);
  localparam logic [CW-1:0] C_FLASH_DLY = CW'(64'(T_FLASH_DLY_MS) * CLK_KHZ);
  localparam logic [CW-1:0] C_FLASH     = CW'(64'(T_FLASH_MS) * CLK_KHZ);
  localparam logic [CW-1:0] C_BAT_PER   = CW'(64'(T_BAT_PER_MS) * CLK_KHZ);
  localparam logic [CW-1:0] C_BEEP      = CW'(64'(T_BEEP_MS) * CLK_KHZ);
  localparam logic [3:0]    OVL_BEEPS   = 4'h3;
  localparam logic [3:0]    BAT_BEEPS   = 4'h6;
  // register map (byte addresses) and fields
  localparam logic [3:0]  ADR_CTRL   = 4'h0;
  localparam logic [3:0]  ADR_STAT   = 4'h4;
  localparam int unsigned CTRL_PULSE = 0;
  localparam logic        RST_PULSE  = 1'b0;
  typedef enum logic [3:0] {
    ST_BOOT, ST_HOMING, ST_LOCKED, ST_OPEN_L, ST_OPEN_R,
    ST_UNBLOCK, ST_OVERLOAD, ST_OFF
  } swg_state_t;
  // contact and sensor levels, all asynchronous to ref_clk
  typedef struct packed {
    logic acs_left;    // access_control_connector left request
    logic acs_right;   // access_control_connector right request
    logic acs_halt;    // access_control_connector halt
    logic pnl_left;    // remote_operator_panel left button
    logic pnl_right;   // remote_operator_panel right button
    logic pnl_halt;    // remote_operator_panel halt button
    logic unblock_ok;  // emergency_unblock_input, 1 = contacts closed
    logic mains_ok;    // mains present
    logic pwr_sw_on;   // mains switch in on position
    logic bat_sw_on;   // battery switch in on position
    logic bat_low;     // discharge comparator, about 22 V
    logic bat_cut;     // cutoff comparator, about 20 V
    logic force_back;  // panel forced against drive rotation
    logic at_home;     // panel in home position
  } swg_contacts_t;
  // debouncer starts from a healthy homed picture, else reset would look like cutoff
  localparam swg_contacts_t CONTACTS_RST = '{unblock_ok: 1'b1, mains_ok: 1'b1,
    pwr_sw_on: 1'b1, bat_sw_on: 1'b1, at_home: 1'b1, default: 1'b0};
  typedef struct packed {
    logic lock_on;      // locking device engaged
    logic drive_power;  // drive supply enabled
    logic motor_left;   // rotate toward left opening
    logic motor_right;  // rotate toward right opening
    logic motor_home;   // rotate back to home
    logic ind_left;     // panel left indicator
    logic ind_right;    // panel right indicator
    logic ind_halt;     // panel red halt indicator
    logic ind_mains;    // controller mains indicator
    logic ind_battery;  // controller battery indicator
    logic acs_pwr_fail; // mains-failure status to connector
    logic acs_bat_fail; // battery-failure status to connector
    logic beeper;       // panel sounder on
    logic tone_hi;      // second tone select
    logic power_off;    // self switch-off request
  } swg_drive_t;
  function automatic logic swg_hit(input logic [CW-1:0] cnt, input logic [CW-1:0] lim);
    return cnt == lim - CW'(1);
  endfunction
endpackage

// *** verif/swg_far_model.sv ***
// far-side model: access control connector levels and operator panel buttons
`timescale 1ns/1ps
module swg_far_model (
  input  wire logic       ref_clk, // system clock
  input  wire logic       rst,     // synchronous reset, high
  input  wire logic [5:0] req,     // wanted levels, connector then panel
  input  wire logic [1:0] lag,     // cycles a new level waits, slow operator
  output logic      [5:0] lvl      // held contact levels
);
  logic [1:0] wait_q;
  // a level is held until asked otherwise, so no request ever lapses on its own
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      lvl    <= 6'h0;
      wait_q <= 2'h0;
    end else if (req == lvl) begin
      wait_q <= 2'h0;
    end else if (wait_q >= lag) begin
      lvl    <= req;
      wait_q <= 2'h0;
    end else begin
      wait_q <= wait_q + 2'h1;
    end
  end
endmodule // swg_far_model

// *** verif/testbench.sv ***
// self-checking bench for the swing gate mode controller
`timescale 1ns/1ps
module testbench;
  import swg_pkg::*;
  logic          ref_clk = 1'b0;
  logic          rst     = 1'b1;
  logic          wb_cyc  = 1'b0;
  logic          wb_stb  = 1'b0;
  logic          wb_we   = 1'b0;
  logic [3:0]    wb_sel  = 4'hf;
  logic [3:0]    wb_adr  = 4'h0;
  logic [31:0]   wb_wdat = 32'h0;
  logic [31:0]   wb_rdat;
  logic          wb_ack;
  logic [5:0]    req     = 6'h0;
  logic [1:0]    lag     = 2'h0;
  logic [5:0]    far;
  swg_contacts_t ct      = '0;
  swg_contacts_t con;
  swg_drive_t    drv;
  int            error_cnt = 0;
  int            samples_checked = 0;
  int            cyc_cnt = 0;
  int            br, hc, lc;
  logic [31:0]   rd;
  logic [5:0]    codes [7] = '{6'h20, 6'h10, 6'h04, 6'h02, 6'h28, 6'h21, 6'h30};
  // shortened timings so every alarm period fits the run
  localparam logic [CW-1:0] B_DEB   = 36'h4;
  localparam logic [CW-1:0] B_BOOT  = 36'h14;
  localparam logic [CW-1:0] B_OVL   = 36'h1e;
  localparam logic [CW-1:0] B_OVLP  = 36'hc8;
  localparam logic [CW-1:0] B_FDLY  = 36'h19;
  localparam logic [CW-1:0] B_FLASH = 36'h5;
  localparam logic [CW-1:0] B_BATP  = 36'h12c;
  localparam logic [CW-1:0] B_BEEP  = 36'h6;

  always #2.5 ref_clk = ~ref_clk;
  assign con = {far, ct[7:0]};

  swg_far_model far_side (.ref_clk(ref_clk), .rst(rst), .req(req), .lag(lag), .lvl(far));

  swg_gate_ctrl #(
    .P_DEB_CYC(B_DEB), .P_BOOT_CYC(B_BOOT), .P_OVL_CYC(B_OVL), .P_OVL_PER_CYC(B_OVLP),
    .P_FLASH_DLY_CYC(B_FDLY), .P_FLASH_CYC(B_FLASH), .P_BAT_PER_CYC(B_BATP),
    .P_BEEP_CYC(B_BEEP)
  ) dut (
    .ref_clk(ref_clk), .rst(rst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat),
    .wb_ack_o(wb_ack), .contacts(con), .drive(drv)
  );

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      error_cnt++;
      wrap_up();
    end
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk);
  endtask

  // classic single cycle; values read at an edge are those settled before it
  task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] d,
                    output logic [31:0] q);
    int w;
    w = 0;
    @(posedge ref_clk);
    wb_cyc  <= 1'b1;
    wb_stb  <= 1'b1;
    wb_we   <= we;
    wb_adr  <= adr;
    wb_wdat <= d;
    do begin
      @(posedge ref_clk);
      w++;
    end while (wb_ack !== 1'b1 && w < 50);
    q = wb_rdat;
    if (w >= 50) chk("wb_ack", 32'h1, 32'h0);
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask

  task automatic status(input string nm, input logic [31:0] mask, input logic [31:0] exp);
    wb(1'b0, ADR_STAT, 32'h0, rd);
    chk(nm, exp, rd & mask);
  endtask

  // beeper rises and changes of halt and left indicators over k cycles
  task automatic watch(input int k, output int b, output int h, output int l);
    swg_drive_t p;
    b = 0;
    h = 0;
    l = 0;
    p = drv;
    repeat (k) begin
      @(posedge ref_clk);
      if (drv.beeper === 1'b1 && p.beeper === 1'b0) b++;
      if (drv.ind_halt !== p.ind_halt) h++;
      if (drv.ind_left !== p.ind_left) l++;
      p = drv;
    end
  endtask

  function automatic logic [1:0] exp_dir(input logic [5:0] r);
    logic l, rt;
    l  = r[5] | r[2];
    rt = r[4] | r[1];
    if (r[0] || (l && rt)) return 2'b00;
    return {l, rt};
  endfunction

  function automatic logic [31:0] exp_beeps(input int burst, input int per, input int win);
    return 32'(burst * win / per);
  endfunction

  initial begin
    void'($urandom(86248));
    ct = '0;
    ct.unblock_ok = 1'b1;
    ct.mains_ok   = 1'b1;
    ct.pwr_sw_on  = 1'b1;
    ct.bat_sw_on  = 1'b1;
    ct.at_home    = 1'b1;
    tick(4);
    rst <= 1'b0;
    tick(4);
    chk("boot", 32'hf, {drv.ind_left, drv.ind_right, drv.ind_halt, drv.beeper});
    hc = 0;
    repeat (10) begin
      tick(1);
      if (drv.tone_hi === 1'b1) hc++;
    end
    chk("two_tone", 32'h1, 32'(hc > 0 && hc < 10));
    tick(40);
    chk("ready", 32'h3, {drv.ind_left, drv.ind_right, drv.ind_halt, drv.lock_on});
    status("state", 32'hf, 32'h2);
    wb(1'b1, ADR_CTRL, 32'h1, rd);
    status("pulse", 32'h100, 32'h100);
    req <= 6'h20;
    tick(16);
    chk("pulse_lock", 32'h2, {drv.lock_on, drv.motor_left});
    req <= 6'h00;
    wb(1'b1, ADR_CTRL, 32'h0, rd);
    wb(1'b0, 4'h8, 32'h0, rd);
    chk("unmapped", 32'h0, rd);
    wb_sel <= 4'he;
    wb(1'b1, ADR_CTRL, 32'h1, rd);
    wb_sel <= 4'hf;
    status("sel_refused", 32'h100, 32'h0);
    tick(16);
    foreach (codes[i]) begin
      lag <= 2'($urandom_range(3));
      req <= codes[i];
      tick(16);
      chk("dir", 32'(exp_dir(codes[i])), {drv.motor_left, drv.motor_right});
      chk("lock", 32'(exp_dir(codes[i]) == 2'b00), 32'(drv.lock_on));
      tick($urandom_range(60, 5));
      chk("held", 32'(exp_dir(codes[i])), {drv.motor_left, drv.motor_right});
      req <= 6'h00;
      tick(16);
      chk("relock", 32'h4, {drv.lock_on, drv.motor_left, drv.motor_right});
      tick(10);
    end
    lag <= 2'h0;
    req <= 6'h20;
    tick(2);
    req <= 6'h00;
    tick(16);
    chk("chatter", 32'h0, 32'(drv.motor_left));
    req <= 6'h20;
    tick(16);
    ct.unblock_ok <= 1'b0;
    tick(16);
    chk("unblock", 32'h0, {drv.lock_on, drv.drive_power});
    ct.unblock_ok <= 1'b1;
    req <= 6'h00;
    tick(16);
    chk("reboot", 32'hf, {drv.ind_left, drv.ind_right, drv.ind_halt, drv.beeper});
    tick(40);
    status("relocked", 32'hf, 32'h2);
    req <= 6'h20;
    tick(16);
    ct.at_home    <= 1'b0;
    ct.force_back <= 1'b1;
    tick(50);
    status("overload", 32'hf, 32'h6);
    ct.force_back <= 1'b0;
    req <= 6'h00;
    tick(250);
    watch(200, br, hc, lc);
    chk("ovl_beeps", exp_beeps(OVL_BEEPS, 200, 200), 32'(br));
    chk("ovl_blink", 32'h1, 32'(hc > 0 && lc > 0));
    status("ovl_stays", 32'hf, 32'h6);
    ct.at_home <= 1'b1;
    tick(16);
    status("ovl_exit", 32'hf, 32'h2);
    ct.mains_ok <= 1'b0;
    tick(16);
    chk("on_bat", 32'hb, {drv.acs_pwr_fail, drv.ind_mains, drv.ind_battery, drv.lock_on});
    status("no_flash", 32'h20, 32'h0);
    tick(30);
    status("flash", 32'h20, 32'h20);
    watch(40, br, hc, lc);
    chk("flash_rate", 32'h1, 32'(hc >= 7 && hc <= 8));
    ct.bat_low <= 1'b1;
    tick(16);
    chk("bat_fail", 32'h1, 32'(drv.acs_bat_fail));
    tick(300);
    watch(300, br, hc, lc);
    chk("bat_beeps", exp_beeps(BAT_BEEPS, 300, 300), 32'(br));
    ct.bat_cut <= 1'b1;
    tick(16);
    chk("off", 32'h1, 32'(drv.power_off));
    status("off_state", 32'hf, 32'h7);
    ct.bat_cut  <= 1'b0;
    ct.bat_low  <= 1'b0;
    ct.mains_ok <= 1'b1;
    tick(16);
    chk("back_on", 32'h0, {drv.power_off, drv.acs_pwr_fail});
    tick(40);
    chk("normal", 32'h5, {drv.ind_mains, drv.ind_battery, drv.lock_on});
    status("normal_state", 32'hf, 32'h2);
    wrap_up();
  end
endmodule // testbench
